/* File: bus_matrix_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_matrix_check (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic [4:0] m_done_out,
	input wire logic [4:0] m_err_out,
	input wire logic [9:0] s_sel_out,
	input wire logic [9:0] s_ready_in,
	input wire logic [319:0] s_addr_out,
	input wire logic [29:0] s_master_out,
	input wire logic [5:0] hs_periph_req_in,
	input wire logic [16:0] pdc_periph_req_in,
	input wire logic [5:0] gen_dma_req_out,
	input wire logic [16:0] periph_dma_req_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	////////////////////////////////////////////////////////////////
	gen_route_a: assert property ($past(sys_rst_in) || gen_dma_req_out == $past(hs_periph_req_in))
		else $error("dma request routing wrong");
	pdc_route_a: assert property ($past(sys_rst_in) || periph_dma_req_out == $past(pdc_periph_req_in))
		else $error("channel request routing wrong");
	sel_done_a: assert property (s_sel_out[0] && s_ready_in[0] |=> !s_sel_out[0] && m_done_out[$past(s_master_out[2:0])])
		else $error("completion not returned to owner");
	sel_hold_a: assert property (s_sel_out[7] && !s_ready_in[7] |=> s_sel_out[7])
		else $error("select dropped before ready");
	done_pulse_a: assert property (m_done_out[1] |=> !m_done_out[1])
		else $error("done longer than one cycle");
	err_done_a: assert property ((m_err_out & ~m_done_out) == 5'h00)
		else $error("error without done");
	flash_path_a: assert property (s_sel_out[3] |-> s_master_out[11:9] == 3'h0)
		else $error("flash reached by wrong master");
	bridge_path_a: assert property (s_sel_out[8] |-> s_master_out[26:24] == 3'h1 || s_master_out[26:24] == 3'h2)
		else $error("bridge reached by wrong master");
	hs_addr_a: assert property (s_sel_out[9] |-> s_addr_out[307] && s_addr_out[319:308] == 12'h400)
		else $error("fast bridge decode wrong");
endmodule
bind multi_layer_bus_matrix bus_matrix_check chk_u (.mclk_in, .sys_rst_in, .m_done_out, .m_err_out,
	.s_sel_out, .s_ready_in, .s_addr_out, .s_master_out, .hs_periph_req_in, .pdc_periph_req_in,
	.gen_dma_req_out, .periph_dma_req_out);
`default_nettype wire

/* File: bus_matrix_regs.vh */
`ifndef BUS_MATRIX_REGS_VH
`define BUS_MATRIX_REGS_VH

// layer counts
`define MX_NUM_MASTERS 5
`define MX_NUM_SLAVES 10

// master indices
`define MX_M_CPU_ID 0
`define MX_M_CPU_SYS 1
`define MX_M_PERIPH_DMA 2
`define MX_M_USB_DMA 3
`define MX_M_GEN_DMA 4

// slave indices
`define MX_S_SRAM0 4'h0
`define MX_S_SRAM1 4'h1
`define MX_S_ROM 4'h2
`define MX_S_FLASH0 4'h3
`define MX_S_FLASH1 4'h4
`define MX_S_USB_RAM 4'h5
`define MX_S_NAND_RAM 4'h6
`define MX_S_EXT_BUS 4'h7
`define MX_S_LS_BRIDGE 4'h8
`define MX_S_HS_BRIDGE 4'h9
// decoder result when no region matches
`define MX_S_NONE 4'hF

// path table: bit s*5+m set when master m is wired to slave s
`define MX_PATH_MAP 50'h0_C6F7_8410_F7DE

// address map: region base (top 12 address bits, top 4 for ext bus) per slave
`define MX_BASE_SRAM0 12'h200
`define MX_BASE_SRAM1 12'h200
`define MX_SRAM1_BIT 19
`define MX_BASE_ROM_HI 12'h001
`define MX_ROM_BIT 19
`define MX_BASE_FLASH_HI 12'h000
`define MX_FLASH1_BIT 18
`define MX_BASE_USB_RAM 12'h201
`define MX_BASE_NAND_RAM 12'h201
// a20 is part of the region base, so the split uses a19 (set: usb ram)
`define MX_USB_RAM_BIT 19
`define MX_BASE_EXT_BUS 4'h6
`define MX_BASE_LS_BRIDGE 12'h400
`define MX_BASE_HS_BRIDGE 12'h400
`define MX_HS_BIT 19

// arbitration policies
`define MX_ARB_ROUND_ROBIN 1'h0
`define MX_ARB_FIXED 1'h1

// bus response codes
`define MX_RESP_OKAY 1'h0
`define MX_RESP_ERROR 1'h1

`endif

/* File: mem_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module mem_slave #(parameter int ID = 0, parameter int LAT = 0) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sel_in,
	input wire logic [31:0] addr_in,
	output logic ready_out,
	output logic [31:0] rdata_out
);
	logic [1:0] cnt;
	logic [31:0] last;
	assign ready_out = sel_in && cnt == 2'(LAT);
	// idle data is the inverse of the last word, so stale reads show
	assign rdata_out = ready_out ? {4'(ID), addr_in[27:0]} : ~last;
	always_ff @(posedge clk_in) begin
		cnt <= (rst_in || !sel_in || ready_out) ? 2'h0 : cnt + 2'h1;
		if (ready_out) last <= rdata_out;
	end
endmodule
`default_nettype wire

/* File: multi_layer_bus_matrix.v */
`timescale 1ns/1ps
`default_nettype none
`include "bus_matrix_regs.vh"

// Function
// - five masters, each on its own layer, run concurrently to different slaves
// - every master layer has its own address decoder and own path to slaves
// - all masters share one identical address map
// - ten slave ports, each with its own arbiter, policy selectable per slave
// - masters: 0 cpu instr/data, 1 cpu system, 2 periph dma, 3 usb dma, 4 dma
// - slaves: sram0, sram1, rom, flash0, flash1, usb ram, nand ram, ext, ls, hs bridge
// - low and high speed bridges are separate ports, usable concurrently
// - high speed bridge carries only spi, serial controller and sd card
// - peripherals on peripheral_dma_channels never request the general dma
// - spi, serial controller and sd card requests go to the general dma only
// - both bridges run on the one master_clock
// - unwired master-slave paths are refused
module multi_layer_bus_matrix #(
	parameter NM = `MX_NUM_MASTERS,
	parameter NS = `MX_NUM_SLAVES,
	parameter AW = 32,
	parameter DW = 32,
	parameter [NS-1:0] ARB_POLICY = {NS{`MX_ARB_ROUND_ROBIN}}
) (
	input wire mclk_in,
	input wire sys_rst_in,
	// master side, flattened per master
	input wire [NM-1:0] m_req_in,
	input wire [NM-1:0] m_write_in,
	input wire [NM*AW-1:0] m_addr_in,
	input wire [NM*DW-1:0] m_wdata_in,
	output reg [NM-1:0] m_done_out,
	output reg [NM-1:0] m_err_out,
	output reg [NM*DW-1:0] m_rdata_out,
	// slave side, flattened per slave
	output reg [NS-1:0] s_sel_out,
	output reg [NS-1:0] s_write_out,
	output reg [NS*AW-1:0] s_addr_out,
	output reg [NS*DW-1:0] s_wdata_out,
	output reg [NS*3-1:0] s_master_out,
	input wire [NS-1:0] s_ready_in,
	input wire [NS*DW-1:0] s_rdata_in,
	// peripheral request routing
	input wire [5:0] hs_periph_req_in,
	input wire [16:0] pdc_periph_req_in,
	output reg [5:0] gen_dma_req_out,
	output reg [16:0] periph_dma_req_out
);

////////////////////////////////////////////////////////////////////////////////
// shared decoder, one instance per master layer

// returns slave index, or MX_S_NONE (4'hF) when nothing matches
function [3:0] decode_slave;
	input [AW-1:0] a;
	begin
		decode_slave = `MX_S_NONE;
		if (a[31:20] == `MX_BASE_SRAM0 && !a[`MX_SRAM1_BIT])
			decode_slave = `MX_S_SRAM0;
		else if (a[31:20] == `MX_BASE_SRAM1 && a[`MX_SRAM1_BIT])
			decode_slave = `MX_S_SRAM1;
		else if (a[31:20] == `MX_BASE_ROM_HI && a[`MX_ROM_BIT])
			decode_slave = `MX_S_ROM;
		else if (a[31:20] == `MX_BASE_FLASH_HI && !a[`MX_FLASH1_BIT])
			decode_slave = `MX_S_FLASH0;
		else if (a[31:20] == `MX_BASE_FLASH_HI && a[`MX_FLASH1_BIT])
			decode_slave = `MX_S_FLASH1;
		else if (a[31:20] == `MX_BASE_USB_RAM && a[`MX_USB_RAM_BIT])
			decode_slave = `MX_S_USB_RAM;
		else if (a[31:20] == `MX_BASE_NAND_RAM && !a[`MX_USB_RAM_BIT])
			decode_slave = `MX_S_NAND_RAM;
		else if (a[31:28] == `MX_BASE_EXT_BUS)
			decode_slave = `MX_S_EXT_BUS;
		else if (a[31:20] == `MX_BASE_LS_BRIDGE && !a[`MX_HS_BIT])
			decode_slave = `MX_S_LS_BRIDGE;
		else if (a[31:20] == `MX_BASE_HS_BRIDGE && a[`MX_HS_BIT])
			decode_slave = `MX_S_HS_BRIDGE;
	end
endfunction

function path_ok;
	input [3:0] s;
	input [2:0] m;
	reg [49:0] map;
	begin
		map = `MX_PATH_MAP;
		path_ok = (s < NS) ? map[s*5+m] : 1'b0;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// per-master decode

reg [3:0] dec_slave [0:NM-1];
reg [NM-1:0] dec_legal;
reg [NM*NS-1:0] want;
integer i, j;

always @* begin
	want = {NM*NS{1'b0}};
	dec_legal = {NM{1'b0}};
	for (i = 0; i < NM; i = i + 1) begin
		dec_slave[i] = decode_slave(m_addr_in[i*AW +: AW]);
		dec_legal[i] = path_ok(dec_slave[i], i[2:0]);
		// each layer only reaches its wired slaves
		for (j = 0; j < NS; j = j + 1)
			want[i*NS+j] = m_req_in[i] && dec_legal[i] && dec_slave[i] == j;
	end
end

////////////////////////////////////////////////////////////////////////////////
// per-slave arbiters

reg [NS-1:0] busy;
reg [2:0] owner [0:NS-1];
reg [2:0] last_gnt [0:NS-1];
reg [2:0] pick [0:NS-1];
reg [NS-1:0] pick_valid;
reg [NM-1:0] m_active;
integer k, n, cand;
integer arb_s, seq_m, seq_s;

always @* begin
	for (arb_s = 0; arb_s < NS; arb_s = arb_s + 1) begin
		pick[arb_s] = 3'h0;
		pick_valid[arb_s] = 1'b0;
		// fixed: lowest index wins; round robin: start after last grant
		for (n = NM; n > 0; n = n - 1) begin
			cand = (ARB_POLICY[arb_s] == `MX_ARB_FIXED) ? (n - 1)
				: (last_gnt[arb_s] + n) % NM;
			if (want[cand*NS+arb_s] && !m_active[cand] && !m_done_out[cand]) begin
				pick[arb_s] = cand[2:0];
				pick_valid[arb_s] = 1'b1;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// transfer control; bridges are two independent ports on master_clock

always @(posedge mclk_in) begin
	if (sys_rst_in) begin
		busy <= {NS{1'b0}};
		m_active <= {NM{1'b0}};
		m_done_out <= {NM{1'b0}};
		m_err_out <= {NM{1'b0}};
		m_rdata_out <= {NM*DW{1'b0}};
		s_sel_out <= {NS{1'b0}};
		s_write_out <= {NS{1'b0}};
		s_addr_out <= {NS*AW{1'b0}};
		s_wdata_out <= {NS*DW{1'b0}};
		s_master_out <= {NS*3{1'b0}};
		for (k = 0; k < NS; k = k + 1) begin
			owner[k] <= 3'h0;
			last_gnt[k] <= 3'h0;
		end
	end else begin
		m_done_out <= {NM{1'b0}};
		m_err_out <= {NM{1'b0}};
		// unmapped or unwired: error pulse, nothing forwarded
		for (seq_m = 0; seq_m < NM; seq_m = seq_m + 1)
			if (m_req_in[seq_m] && !dec_legal[seq_m] && !m_done_out[seq_m]
				&& !m_active[seq_m]) begin
				m_done_out[seq_m] <= 1'b1;
				m_err_out[seq_m] <= `MX_RESP_ERROR;
			end
		for (seq_s = 0; seq_s < NS; seq_s = seq_s + 1) begin
			if (busy[seq_s]) begin
				if (s_ready_in[seq_s]) begin
					busy[seq_s] <= 1'b0;
					s_sel_out[seq_s] <= 1'b0;
					m_active[owner[seq_s]] <= 1'b0;
					m_done_out[owner[seq_s]] <= 1'b1;
					m_err_out[owner[seq_s]] <= `MX_RESP_OKAY;
					m_rdata_out[owner[seq_s]*DW +: DW] <= s_rdata_in[seq_s*DW +: DW];
				end
			end else if (pick_valid[seq_s]) begin
				// bridges 8 and 9 each arbitrate alone, so both may run at once
				busy[seq_s] <= 1'b1;
				owner[seq_s] <= pick[seq_s];
				last_gnt[seq_s] <= pick[seq_s];
				m_active[pick[seq_s]] <= 1'b1;
				s_sel_out[seq_s] <= 1'b1;
				s_write_out[seq_s] <= m_write_in[pick[seq_s]];
				s_addr_out[seq_s*AW +: AW] <= m_addr_in[pick[seq_s]*AW +: AW];
				s_wdata_out[seq_s*DW +: DW] <= m_wdata_in[pick[seq_s]*DW +: DW];
				s_master_out[seq_s*3 +: 3] <= pick[seq_s];
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// peripheral request routing

always @(posedge mclk_in) begin
	if (sys_rst_in) begin
		gen_dma_req_out <= 6'h00;
		periph_dma_req_out <= 17'h00000;
	end else begin
		// high speed bridge peripherals: sd card, spi tx/rx, serial ctrl tx/rx, spare
		gen_dma_req_out <= hs_periph_req_in;
		// channel-served peripherals have no path to the general dma
		periph_dma_req_out <= pdc_periph_req_in;
	end
end

endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk_in, sys_rst_in;
	logic [4:0] m_req_in, m_write_in;
	logic [159:0] m_addr_in, m_wdata_in;
	wire [4:0] m_done_out, m_err_out;
	wire [159:0] m_rdata_out;
	wire [9:0] s_sel_out, s_ready_in;
	wire [319:0] s_addr_out, s_rdata_in;
	wire [29:0] s_master_out;
	logic [5:0] hs_periph_req_in;
	logic [16:0] pdc_periph_req_in;
	wire [5:0] gen_dma_req_out;
	wire [16:0] periph_dma_req_out;
	int error_cnt = 0, compares = 0, cyc = 0, c0;
	multi_layer_bus_matrix dut_u (.mclk_in, .sys_rst_in, .m_req_in, .m_write_in, .m_addr_in,
		.m_wdata_in, .m_done_out, .m_err_out, .m_rdata_out, .s_sel_out, .s_write_out(),
		.s_addr_out, .s_wdata_out(), .s_master_out, .s_ready_in, .s_rdata_in,
		.hs_periph_req_in, .pdc_periph_req_in, .gen_dma_req_out, .periph_dma_req_out);
	for (genvar g = 0; g < 10; g++) begin : sl
		mem_slave #(.ID(g), .LAT(g % 3)) mem_u (.clk_in(mclk_in), .rst_in(sys_rst_in),
			.sel_in(s_sel_out[g]), .addr_in(s_addr_out[g*32+:32]),
			.ready_out(s_ready_in[g]), .rdata_out(s_rdata_in[g*32+:32]));
	end
	////////////////////////////////////////////////////////////////
	task give_verdict;
		if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input int m, input logic [31:0] a, input int s, input logic e);
		int n = 0;
		m_addr_in[m*32+:32] = a;
		m_req_in[m] = 1'b1;
		while (m_done_out[m] !== 1'b1 && n < 200) begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		if (n >= 200) error_cnt++;
		chk({31'h0, m_err_out[m]}, {31'h0, e});
		if (!e) chk(m_rdata_out[m*32+:32], {4'(s), a[27:0]});
		m_req_in[m] = 1'b0;
		@(posedge mclk_in);
		#1;
	endtask
	////////////////////////////////////////////////////////////////
	task t_map;
		acc(1, 32'h2000_0010, 0, 1'b0);
		acc(4, 32'h2008_0020, 1, 1'b0);
		acc(0, 32'h0000_0100, 3, 1'b0);
		acc(0, 32'h0004_0100, 4, 1'b0);
		acc(2, 32'h6000_0040, 7, 1'b0);
		acc(2, 32'h0018_0040, 2, 1'b0);
		acc(1, 32'h2018_0010, 5, 1'b0);
		acc(2, 32'h2010_0020, 6, 1'b0);
		acc(0, 32'h2000_0000, 0, 1'b1);
		acc(3, 32'h4000_0000, 0, 1'b1);
		acc(1, 32'h8000_0000, 0, 1'b1);
	endtask
	task t_conc;
		c0 = cyc;
		fork
			acc(0, 32'h0000_0200, 3, 1'b0);
			acc(1, 32'h4000_0008, 8, 1'b0);
			acc(2, 32'h4008_000C, 9, 1'b0);
			acc(3, 32'h2000_0400, 0, 1'b0);
			acc(4, 32'h6000_0800, 7, 1'b0);
		join
		// serialised layers would need well over eight cycles
		chk({31'h0, cyc - c0 <= 8}, 32'h1);
	endtask
	task t_contend;
		fork
			acc(1, 32'h2000_0100, 0, 1'b0);
			acc(2, 32'h2000_0200, 0, 1'b0);
			acc(4, 32'h2000_0300, 0, 1'b0);
		join
	endtask
	task t_route;
		hs_periph_req_in = 6'h2A;
		pdc_periph_req_in = 17'h1_5A5A;
		@(posedge mclk_in);
		#1;
		chk({26'h0, gen_dma_req_out}, 32'h2A);
		chk({15'h0, periph_dma_req_out}, 32'h1_5A5A);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			give_verdict;
		end
	end
	initial begin
		sys_rst_in = 1'b1;
		m_req_in = 5'h00;
		m_write_in = 5'h00;
		m_addr_in = 160'h0;
		m_wdata_in = 160'h0;
		hs_periph_req_in = 6'h00;
		pdc_periph_req_in = 17'h0;
		repeat (4) @(posedge mclk_in);
		#1;
		sys_rst_in = 1'b0;
		t_map;
		t_conc;
		t_contend;
		t_route;
		give_verdict;
	end
endmodule
`default_nettype wire
